// ==== hw/bif_fetch.sv ====
// Purpose: Byte instruction prefetch with stall output
// Assumes: Memory answers a four-phase req/ack, data stable while ack high
// Notes:   Notes on behaviour below
// Notes on behaviour
// R1: Byte address is base shifted left three plus offset, nineteen bits.
// R2: Read eight-byte groups through own port, hold until consumed.
// R3: Taking last byte of a group starts the next group read.
// R4: Hand out one 8-bit opcode byte per take, not words.
// R5: Offset counter is sixteen bits wide and wraps.
// R6: Controller issues fetches blindly, relying on the stall signal.
// R7: Busy memory interface raises not-ready to hold off the clock.
// R8: Stall response settles within one 150 ns microcycle.
// R9: No detection of writes to already buffered code bytes.
// R10: Wide reads return 64 bits; low two word-address bits are zero.
// R11: Loading offset or base discards group and refetches first.
// R12: Missing group stalls the processor via not-ready.
`include "bif_params.svh"
module bif_fetch
   import bif_pkg::*;
#(
   parameter int BASE_W    = `BIF_BASE_W,
   parameter int PC_W      = `BIF_PC_W,
   parameter int GRP_BYTES = `BIF_GRP_BYTES
) (
   input  wire logic                       clk_i,
   input  wire logic                       rst_b_i,
   input  wire logic                       load_pc_i,
   input  wire logic [PC_W-1:0]            pc_i,
   input  wire logic                       load_base_i,
   input  wire logic [BASE_W-1:0]          base_i,
   input  wire logic                       take_i,
   output logic      [7:0]                 byte_o,
   output logic                            byte_valid_o,
   output logic                            not_ready_o,
   output logic                            mem_req_o,
   output logic [BASE_W+`BIF_BASE_SHIFT-`BIF_WORD_LSB-1:0] mem_addr_o,
   input  wire logic                       mem_ack_i,
   input  wire logic [GRP_BYTES*8-1:0]     mem_rdata_i
);
   localparam int ADDR_W = BASE_W + `BIF_BASE_SHIFT;
   localparam int WADR_W = ADDR_W - `BIF_WORD_LSB;
   localparam int LSB    = $clog2(GRP_BYTES);
   localparam int STALL  = `BIF_STALL_CYC;

   if (GRP_BYTES * 8 != `BIF_MEM_W || (1 << LSB) != GRP_BYTES || LSB != `BIF_BASE_SHIFT || PC_W > ADDR_W) begin : g_chk
      $error("bif_fetch: unsupported width parameters");
   end

   bif_state_t       st_r, st_nxt;
   logic [PC_W-1:0]   pc_r, pc_nxt;
   logic [BASE_W-1:0] base_r, base_nxt;
   logic              stale_r, stale_nxt;
   logic              rst_q1_r, rst_n;
   logic              ack_q1_r, ack_s_r;
   logic              loading, take_ok, last, grp_wr;

   bif_grp_if #(.BYTES(GRP_BYTES)) grp ();

   bif_group_buf #(.BYTES(GRP_BYTES)) u_buf (
      .clk_i   (clk_i),
      .rst_n_i (rst_n),
      .grp     (grp)
   );

   // R1: nineteen-bit byte address
   function automatic logic [ADDR_W-1:0] byte_addr(input logic [BASE_W-1:0] b, input logic [PC_W-1:0] p);
      byte_addr = {b, `BIF_BASE_SHIFT'(0)} + ADDR_W'(p);
   endfunction : byte_addr

   // R10: low word bits forced zero
   function automatic logic [WADR_W-1:0] word_addr(input logic [BASE_W-1:0] b, input logic [PC_W-1:0] p);
      logic [ADDR_W-1:0] a;
      a = byte_addr(b, p);
      word_addr = {a[ADDR_W-1:LSB], (LSB-`BIF_WORD_LSB)'(0)};
   endfunction : word_addr

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rst_q1_r <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_q1_r <= 1'b1;
         rst_n    <= rst_q1_r;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ack_q1_r <= 1'b0;
         ack_s_r  <= 1'b0;
      end else begin
         ack_q1_r <= mem_ack_i;
         ack_s_r  <= ack_q1_r;
      end
   end

   assign loading = load_pc_i | load_base_i;
   assign take_ok = take_i & byte_valid_o & (st_r == BIF_ST_READY);
   assign last    = (pc_r[LSB-1:0] == LSB'(GRP_BYTES - 1));

   always_comb begin
      pc_nxt    = pc_r;
      base_nxt  = base_r;
      st_nxt    = st_r;
      stale_nxt = stale_r;
      grp_wr    = 1'b0;
      if (load_pc_i) begin
         pc_nxt = pc_i;
      end
      if (load_base_i) begin
         base_nxt = base_i;
      end
      case (st_r)
         BIF_ST_READY: begin
            // R11: load forces a fresh fetch
            if (loading) begin
               st_nxt = BIF_ST_REQ;
            end else if (take_ok) begin
               // R5: sixteen-bit offset step
               pc_nxt = pc_r + PC_W'(1);
               // R3: prefetch after last byte
               if (last) begin
                  st_nxt = BIF_ST_REQ;
               end
            end
         end
         BIF_ST_REQ: begin
            if (loading) begin
               stale_nxt = 1'b1;
            end
            if (ack_s_r) begin
               // R2: capture the wide group
               grp_wr = ~stale_r & ~loading;
               st_nxt = BIF_ST_RELEASE;
            end
         end
         BIF_ST_RELEASE: begin
            if (loading) begin
               stale_nxt = 1'b1;
            end
            if (!ack_s_r) begin
               // R11: stale group is refetched
               st_nxt    = (stale_r | loading) ? BIF_ST_REQ : BIF_ST_READY;
               stale_nxt = 1'b0;
            end
         end
         default: begin
            st_nxt = BIF_ST_REQ;
         end
      endcase
   end

   assign grp.wr    = grp_wr;
   assign grp.wdata = mem_rdata_i;
   assign grp.sel   = pc_nxt[LSB-1:0];

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         st_r    <= BIF_ST_RELEASE;
         stale_r <= 1'b1;
         pc_r    <= `BIF_PC_RST;
         base_r  <= `BIF_BASE_RST;
      end else begin
         st_r    <= st_nxt;
         stale_r <= stale_nxt;
         pc_r    <= pc_nxt;
         base_r  <= base_nxt;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         mem_req_o  <= 1'b0;
         mem_addr_o <= '0;
      end else begin
         mem_req_o <= (st_nxt == BIF_ST_REQ);
         // R1: latch address at fetch start
         if (st_nxt == BIF_ST_REQ && st_r != BIF_ST_REQ) begin
            mem_addr_o <= word_addr(base_nxt, pc_nxt);
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         byte_o       <= 8'h00;
         byte_valid_o <= 1'b0;
         not_ready_o  <= 1'b1;
      end else begin
         // R4: one opcode byte out
         byte_o       <= grp.rbyte;
         byte_valid_o <= (st_r == BIF_ST_READY) && (st_nxt == BIF_ST_READY);
         // R7: stall while fetch is busy
         // R8: one-cycle stall response
         // R12: missing group stalls
         not_ready_o  <= (st_nxt != BIF_ST_READY);
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n);

   sequence s_take_last;
      take_ok && last && !loading;
   endsequence

   sequence s_take_mid;
      take_ok && !last && !loading;
   endsequence

   a_addr_form: assert property ($rose(mem_req_o) |-> mem_addr_o == word_addr(base_r, pc_r)) // R1
      else $error("fetch address not base*8 plus offset");
   a_group_hold: assert property (byte_valid_o && !take_i && !loading |=> byte_valid_o && $stable(byte_o)) // R2
      else $error("buffered byte lost without take");
   a_prefetch_start: assert property (s_take_last |=> mem_req_o && !byte_valid_o) // R3
      else $error("no prefetch after last byte");
   a_byte_step: assert property (s_take_mid |=> byte_valid_o && pc_r == $past(pc_r) + PC_W'(1)) // R4
      else $error("byte step failed");
   a_pc_wrap: assert property (take_ok && !loading && pc_r == '1 |=> pc_r == '0) // R5
      else $error("offset did not wrap");
   a_stall_busy: assert property (st_r != BIF_ST_READY |-> not_ready_o && !byte_valid_o) // R7
      else $error("busy fetch without not-ready");
   a_stall_bound: assert property (loading |-> ##[1:STALL] not_ready_o) // R8
      else $error("stall too late");
   a_wide_align: assert property (mem_req_o |-> mem_addr_o[LSB-`BIF_WORD_LSB-1:0] == '0) // R10
      else $error("wide read address not aligned");
   a_reload_drop: assert property (loading |=> !byte_valid_o ##1 !byte_valid_o) // R11
      else $error("bytes supplied after reload");
   a_missing_grp: assert property (take_ok && last |=> not_ready_o) // R12
      else $error("missing group not stalled");
endmodule : bif_fetch

// ==== hw/bif_params.svh ====
// Purpose: Constants for the byte instruction prefetch block
// Assumes: 25 MHz system clock
// Notes:   Widths, counts and reset values
`ifndef BIF_PARAMS_SVH
`define BIF_PARAMS_SVH
`define BIF_BASE_W      16
`define BIF_PC_W        16
`define BIF_BASE_SHIFT  3
`define BIF_GRP_BYTES   8
`define BIF_MEM_W       64
`define BIF_OPC_W       8
`define BIF_WORD_LSB    1
`define BIF_PC_RST      16'h0000
`define BIF_BASE_RST    16'h0000
`define BIF_CLK_NS      40
`define BIF_UCYCLE_NS   150
`define BIF_STALL_CYC   ((`BIF_UCYCLE_NS / `BIF_CLK_NS) < 1 ? 1 : (`BIF_UCYCLE_NS / `BIF_CLK_NS))
`endif

// ==== hw/bif_pkg.sv ====
// Purpose: Types for the byte instruction prefetch block
// Assumes: Nothing
// Notes:   Fetch sequencer states
package bif_pkg;
   typedef enum logic [1:0] {
      BIF_ST_READY   = 2'b00,
      BIF_ST_REQ     = 2'b01,
      BIF_ST_RELEASE = 2'b11
   } bif_state_t;
   typedef logic [7:0] bif_byte_t;
endpackage : bif_pkg

// ==== hw/bif_grp_if.sv ====
// Purpose: Link between fetch sequencer and group store
// Assumes: One writer, one reader
// Notes:   Byte select is combinational
interface bif_grp_if #(parameter int BYTES = 8);
   logic                     wr;
   logic [BYTES*8-1:0]       wdata;
   logic [$clog2(BYTES)-1:0] sel;
   logic [7:0]               rbyte;
   modport fill  (output wr, output wdata, output sel, input rbyte);
   modport store (input wr, input wdata, input sel, output rbyte);
endinterface : bif_grp_if

// ==== hw/bif_group_buf.sv ====
// Purpose: Holds one fetched instruction group
// Assumes: Byte 0 in the lowest lane of the wide word
// Notes:   No snooping of later memory writes
module bif_group_buf #(
   parameter int BYTES = 8
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   bif_grp_if.store  grp
);
   logic [7:0] mem_r [BYTES];

   // R2: group held until reloaded
   // R9: no write snooping
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < BYTES; i++) begin
            mem_r[i] <= 8'h00;
         end
      end else if (grp.wr) begin
         for (int i = 0; i < BYTES; i++) begin
            mem_r[i] <= grp.wdata[i*8 +: 8];
         end
      end
   end

   assign grp.rbyte = mem_r[grp.sel];
endmodule : bif_group_buf

// ==== sim/bif_mem_model.sv ====
// Purpose: Memory port partner for the prefetch block
// Assumes: Four-phase req/ack, latency from lat_i
// Notes:   Data scrambles while not acknowledged
module bif_mem_model (
   input  wire logic        clk_i,
   input  wire logic        req_i,
   input  wire logic [17:0] addr_i,
   input  wire logic [3:0]  lat_i,
   output logic             ack_o,
   output logic [63:0]      rdata_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0]  cnt_r;
   logic [18:0] a;
   initial begin
      ack_o = 1'b0;
      rdata_o = 64'h0;
      cnt_r = 4'h0;
   end
   always @(posedge clk_i) begin
      if (req_i && !ack_o && cnt_r >= lat_i) begin
         ack_o <= 1'b1;
         for (int k = 0; k < 8; k++) begin
            a = {addr_i[17:2], 3'h0} + 19'(k);
            rdata_o[8*k +: 8] <= a[7:0] ^ {a[15:11], a[18:16]};
         end
      end else if (!ack_o) begin
         cnt_r <= req_i ? cnt_r + 4'h1 : 4'h0;
         rdata_o <= ~rdata_o;
      end else if (!req_i) begin
         ack_o <= 1'b0;
         cnt_r <= 4'h0;
         rdata_o <= ~rdata_o;
      end
   end
endmodule : bif_mem_model

// ==== sim/bif_fetch_tb_top.sv ====
// Purpose: Self-checking bench for the prefetch block
// Assumes: Inputs driven at falling edge
// Notes:   Memory latency varied per scenario
module bif_fetch_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i = 1'b0;
   logic        rst_b_i = 1'b0;
   logic        load_pc_i = 1'b0;
   logic        load_base_i = 1'b0;
   logic        take_i = 1'b0;
   logic [15:0] pc_i = 16'h0;
   logic [15:0] base_i = 16'h0;
   logic [7:0]  byte_o;
   logic        byte_valid_o, not_ready_o, mem_req_o, mem_ack_i;
   logic [17:0] mem_addr_o;
   logic [63:0] mem_rdata_i;
   logic [3:0]  lat = 4'h0;
   logic [15:0] pc_v = 16'h0;
   logic [15:0] base_v = 16'h0;
   int          err_total = 0;
   int          total_checks = 0;
   always #20 clk_i = ~clk_i;
   bif_fetch dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .load_pc_i(load_pc_i), .pc_i(pc_i),
      .load_base_i(load_base_i), .base_i(base_i), .take_i(take_i), .byte_o(byte_o),
      .byte_valid_o(byte_valid_o), .not_ready_o(not_ready_o), .mem_req_o(mem_req_o),
      .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i));
   bif_mem_model mem (.clk_i(clk_i), .req_i(mem_req_o), .addr_i(mem_addr_o), .lat_i(lat),
      .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));
   function automatic logic [18:0] baddr();
      return (19'(base_v) << 3) + 19'(pc_v);
   endfunction : baddr
   function automatic logic [7:0] mbyte(input logic [18:0] a);
      return a[7:0] ^ {a[15:11], a[18:16]};
   endfunction : mbyte
   task automatic end_sim();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_sim
   task automatic chk_val(input logic [18:0] got, input logic [18:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t value %h expected %h", $time, got, exp);
      end
   endtask : chk_val
   task automatic chk_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t flag %b expected %b", $time, got, exp);
      end
   endtask : chk_bit
   task automatic wait_grp();
      logic [17:0] seen;
      logic [18:0] a;
      seen = 18'h0;
      a = baddr();
      for (int n = 0; byte_valid_o !== 1'b1; n++) begin
         if (mem_req_o === 1'b1) seen = mem_addr_o;
         if (n > 200) begin
            err_total++;
            $display("BAD %0t no group", $time);
            end_sim();
         end
         @(negedge clk_i);
      end
      chk_val(19'(seen), 19'({a[18:3], 2'h0}));
      chk_bit(not_ready_o, 1'b0);
   endtask : wait_grp
   task automatic take_run(input int n);
      for (int i = 0; i < n; i++) begin
         chk_val(19'(byte_o), 19'(mbyte(baddr())));
         chk_bit(byte_valid_o, 1'b1);
         take_i = 1'b1;
         pc_v = pc_v + 16'h1;
         @(negedge clk_i);
      end
      take_i = 1'b0;
   endtask : take_run
   task automatic load(input logic [15:0] p, input logic [15:0] b, input logic lp, input logic lb);
      pc_i = p;
      base_i = b;
      load_pc_i = lp;
      load_base_i = lb;
      @(negedge clk_i);
      load_pc_i = 1'b0;
      load_base_i = 1'b0;
      if (lp) pc_v = p;
      if (lb) base_v = b;
      chk_bit(byte_valid_o, 1'b0);
      chk_bit(not_ready_o, 1'b1);
   endtask : load
   task automatic last_taken();
      logic [18:0] a;
      a = baddr();
      chk_bit(byte_valid_o, 1'b0);
      chk_bit(not_ready_o, 1'b1);
      chk_bit(mem_req_o, 1'b1);
      chk_val(19'(mem_addr_o), 19'({a[18:3], 2'h0}));
   endtask : last_taken
   task automatic sc_first_groups();
      wait_grp();
      take_run(8);
      last_taken();
      wait_grp();
      take_run(1);
   endtask : sc_first_groups
   task automatic sc_offset_wrap();
      lat = 4'h2;
      load(16'hFFFD, 16'h1235, 1'b1, 1'b1);
      wait_grp();
      take_run(3);
      last_taken();
      wait_grp();
      take_run(2);
   endtask : sc_offset_wrap
   task automatic sc_load_in_flight();
      lat = 4'h6;
      load(16'h0006, 16'h0000, 1'b1, 1'b0);
      wait_grp();
      take_run(2);
      last_taken();
      load(16'h0000, 16'h0040, 1'b0, 1'b1);
      take_i = 1'b1;
      repeat (4) @(negedge clk_i);
      take_i = 1'b0;
      chk_bit(byte_valid_o, 1'b0);
      wait_grp();
      take_run(1);
   endtask : sc_load_in_flight
   initial begin
      repeat (6) @(negedge clk_i);
      chk_bit(byte_valid_o, 1'b0);
      chk_bit(not_ready_o, 1'b1);
      chk_bit(mem_req_o, 1'b0);
      rst_b_i = 1'b1;
      sc_first_groups();
      sc_offset_wrap();
      sc_load_in_flight();
      end_sim();
   end
endmodule : bif_fetch_tb_top
